// ===== rtl/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
  // I/O port addresses seen by the block.
  localparam logic [15:0] ADDR_INDEX    = 16'h002E;
  localparam logic [15:0] ADDR_DATA     = 16'h002F;
  localparam logic [15:0] ADDR_INTERVAL = 16'h0440;
  // Configuration register indices, the watchdog device number and the entry and exit keys.
  localparam logic [7:0] IDX_LDN   = 8'h07;
  localparam logic [7:0] IDX_ACT   = 8'h30;
  localparam logic [7:0] IDX_UNIT  = 8'hF5;
  localparam logic [7:0] IDX_COUNT = 8'hF6;
  localparam logic [7:0] LDN_WDT   = 8'h08;
  localparam logic [7:0] ENTER_KEY = 8'h87;
  localparam logic [7:0] EXIT_KEY  = 8'hAA;
  // Interval code range on the interval port.
  localparam logic [7:0] INTERVAL_MIN = 8'h01;
  localparam logic [7:0] INTERVAL_MAX = 8'h3F;
  // Reset values and field positions.
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam int         ACT_EN_BIT   = 0;
  localparam int         UNIT_MIN_BIT = 0;
  localparam int         UNIT_IRQ_BIT = 1;
  // Timing: one count unit is one second at the core clock, or sixty seconds when the minute unit bit is set.
  localparam int UNIT_TIME_S    = 1;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CYCLES_PER_SEC = UNIT_TIME_S * 1000000000 / CLK_PERIOD_NS;
  localparam logic [5:0] SEC_PER_MIN_LAST = 6'h3B;
  typedef enum logic [1:0] {
    CFG_LOCKED = 2'b00,
    CFG_KEY1   = 2'b01,
    CFG_OPEN   = 2'b10
  } cfg_state_t;
endpackage : wdt_pkg
`default_nettype wire

// ===== rtl/wdt_tick.sv
`default_nettype none
module wdt_tick #(
  parameter int CYCLES = 20000000
) (
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_restart,
  output logic      o_tick
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_reg;

  // Restarting on every load makes the first unit after a load a full unit.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
    end else if (i_restart || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  assign o_tick = (cnt_reg == LAST) && !i_restart;
endmodule : wdt_tick
`default_nettype wire

// ===== rtl/system_watchdog_timer.sv
`default_nettype none
module system_watchdog_timer #(
  parameter int CYCLES_PER_SEC = wdt_pkg::CYCLES_PER_SEC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  output logic             o_cpu_reset,
  output logic             o_irq
);
  wdt_pkg::cfg_state_t cfg_reg;
  logic [7:0] index_reg;
  logic [7:0] ldn_reg;
  logic [7:0] act_reg;
  logic [7:0] unit_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [5:0] sec_reg;
  logic       armed_reg;
  logic       sec_tick;

  wire cfg_open  = (cfg_reg == wdt_pkg::CFG_OPEN);
  wire idx_wr    = i_io_wr && i_io_addr == wdt_pkg::ADDR_INDEX;
  wire data_wr   = i_io_wr && i_io_addr == wdt_pkg::ADDR_DATA && cfg_open;
  wire wdt_sel   = (ldn_reg == wdt_pkg::LDN_WDT);
  wire iv_wr     = i_io_wr && i_io_addr == wdt_pkg::ADDR_INTERVAL;
  wire iv_rd     = i_io_rd && i_io_addr == wdt_pkg::ADDR_INTERVAL;
  wire iv_ok     = i_io_wdata <= wdt_pkg::INTERVAL_MAX;
  wire iv_load   = iv_wr && iv_ok;
  wire cnt_load  = data_wr && wdt_sel && index_reg == wdt_pkg::IDX_COUNT;
  wire load      = iv_load || cnt_load;
  wire running   = armed_reg && act_reg[wdt_pkg::ACT_EN_BIT] && count_reg != 8'h00;
  wire unit_min  = unit_reg[wdt_pkg::UNIT_MIN_BIT];
  wire unit_tick = sec_tick && (!unit_min || sec_reg == wdt_pkg::SEC_PER_MIN_LAST);
  wire expire    = running && !load && unit_tick && count_reg == 8'h01;

  wdt_tick #(
    .CYCLES (CYCLES_PER_SEC)
  ) u_tick (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_restart  (load || !running),
    .o_tick     (sec_tick)
  );

  // Two writes of the entry key open the configuration space.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_reg <= wdt_pkg::CFG_LOCKED;
    end else if (idx_wr) begin
      case (cfg_reg)
        wdt_pkg::CFG_LOCKED: begin
          cfg_reg <= (i_io_wdata == wdt_pkg::ENTER_KEY) ? wdt_pkg::CFG_KEY1 : wdt_pkg::CFG_LOCKED;
        end
        wdt_pkg::CFG_KEY1: begin
          cfg_reg <= (i_io_wdata == wdt_pkg::ENTER_KEY) ? wdt_pkg::CFG_OPEN : wdt_pkg::CFG_LOCKED;
        end
        wdt_pkg::CFG_OPEN: begin
          if (i_io_wdata == wdt_pkg::EXIT_KEY) begin
            cfg_reg <= wdt_pkg::CFG_LOCKED;
          end
        end
        default: begin
          cfg_reg <= wdt_pkg::CFG_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      index_reg <= wdt_pkg::RST_BYTE;
    end else if (idx_wr && cfg_open && i_io_wdata != wdt_pkg::EXIT_KEY) begin
      index_reg <= i_io_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ldn_reg  <= wdt_pkg::RST_BYTE;
      act_reg  <= wdt_pkg::RST_BYTE;
      unit_reg <= wdt_pkg::RST_BYTE;
    end else if (data_wr) begin
      if (index_reg == wdt_pkg::IDX_LDN) begin
        ldn_reg <= i_io_wdata;
      end
      if (wdt_sel && index_reg == wdt_pkg::IDX_ACT) begin
        act_reg <= i_io_wdata;
      end
      if (wdt_sel && index_reg == wdt_pkg::IDX_UNIT) begin
        unit_reg <= i_io_wdata;
      end
    end
  end

  // A load always beats a decrement, so a refresh landing on the last unit wins.
  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = i_io_wdata;
    end else if (running && unit_tick) begin
      count_next = count_reg - 8'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_reg <= wdt_pkg::RST_BYTE;
    end else begin
      count_reg <= count_next;
    end
  end

  // Minute prescale runs from seconds; it restarts with every load.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sec_reg <= 6'h00;
    end else if (load || !running) begin
      sec_reg <= 6'h00;
    end else if (sec_tick) begin
      sec_reg <= (sec_reg == wdt_pkg::SEC_PER_MIN_LAST) ? 6'h00 : sec_reg + 6'h01;
    end
  end

  // Interval codes above INTERVAL_MAX are ignored rather than clipped; code 00 is loaded and stops the count.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      armed_reg <= 1'b0;
    end else if (load) begin
      armed_reg <= 1'b1;
    end else if (iv_rd || expire) begin
      armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cpu_reset <= 1'b0;
    end else begin
      o_cpu_reset <= expire && !unit_reg[wdt_pkg::UNIT_IRQ_BIT];
    end
  end

  // The request holds until a load or a read of the interval port; an expiry wins.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else if (expire && unit_reg[wdt_pkg::UNIT_IRQ_BIT]) begin
      o_irq <= 1'b1;
    end else if (load || iv_rd) begin
      o_irq <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata <= wdt_pkg::RST_BYTE;
    end else if (i_io_rd) begin
      o_io_rdata <= wdt_pkg::RST_BYTE;
      if (i_io_addr == wdt_pkg::ADDR_INTERVAL) begin
        o_io_rdata <= count_reg;
      end else if (cfg_open && i_io_addr == wdt_pkg::ADDR_INDEX) begin
        o_io_rdata <= index_reg;
      end else if (cfg_open && i_io_addr == wdt_pkg::ADDR_DATA) begin
        case (index_reg)
          wdt_pkg::IDX_LDN:   o_io_rdata <= ldn_reg;
          wdt_pkg::IDX_ACT:   o_io_rdata <= wdt_sel ? act_reg : wdt_pkg::RST_BYTE;
          wdt_pkg::IDX_UNIT:  o_io_rdata <= wdt_sel ? unit_reg : wdt_pkg::RST_BYTE;
          wdt_pkg::IDX_COUNT: o_io_rdata <= wdt_sel ? count_reg : wdt_pkg::RST_BYTE;
          default:            o_io_rdata <= wdt_pkg::RST_BYTE;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  AST_EXPIRE_FIRES: assert property (
    running && !load && unit_tick && count_reg == 8'h01 |=> o_cpu_reset || o_irq)
    else $error("expiry did not raise reset or interrupt");
  AST_INTERVAL_LOAD: assert property (
    iv_wr && iv_ok |=> count_reg == $past(i_io_wdata) && armed_reg)
    else $error("interval write did not load and arm");
  AST_RANGE_IGNORED: assert property (
    iv_wr && !iv_ok && !cnt_load && !(running && unit_tick) |=> $stable(count_reg))
    else $error("out-of-range interval changed the count");
  AST_REFRESH_NO_FIRE: assert property (
    iv_load |=> !o_cpu_reset ##1 !o_cpu_reset)
    else $error("reset fired right after a refresh");
  AST_READ_DISABLES: assert property (
    iv_rd && !load && !expire |=> !armed_reg && !o_irq ##1 !o_cpu_reset)
    else $error("read of interval port did not disable");
  AST_LDN_SELECT: assert property (
    data_wr && index_reg == wdt_pkg::IDX_LDN |=> ldn_reg == $past(i_io_wdata))
    else $error("logical device number not stored");
  AST_INACTIVE_SILENT: assert property (
    !act_reg[wdt_pkg::ACT_EN_BIT] |=> !o_cpu_reset && !$rose(o_irq))
    else $error("inactive watchdog fired");
  AST_SEC_DECREMENT: assert property (
    running && !load && sec_tick && !unit_min |=> count_reg == $past(count_reg) - 8'h01)
    else $error("second unit did not decrement per second");
  AST_COUNT_LOAD: assert property (
    cnt_load |=> count_reg == $past(i_io_wdata) && armed_reg)
    else $error("count register write did not load");
  AST_EXIT_KEY: assert property (
    cfg_open && idx_wr && i_io_wdata == wdt_pkg::EXIT_KEY |=> cfg_reg == wdt_pkg::CFG_LOCKED)
    else $error("exit key did not close configuration");
  AST_ZERO_STOPPED: assert property (
    count_reg == 8'h00 && !load |=> count_reg == 8'h00 && !o_cpu_reset && !$rose(o_irq))
    else $error("zero count did not stay stopped");

  COV_RESET_FIRED: cover property (o_cpu_reset);
  COV_IRQ_FIRED:   cover property ($rose(o_irq));
  COV_REFRESH:     cover property (running ##1 iv_load);
  COV_DISABLE:     cover property (running ##1 iv_rd);
endmodule : system_watchdog_timer
`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPS = 4;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        cpu_rst;
  logic        irq;
  int          err_total = 0;
  int          tests_run = 0;
  // Each row: index, data written through the data port, data read back.
  logic [7:0]  rows [4][3] = '{'{8'h07, 8'h08, 8'h08}, '{8'h30, 8'h01, 8'h01},
                               '{8'hF5, 8'h00, 8'h00}, '{8'hF6, 8'h00, 8'h00}};

  system_watchdog_timer #(.CYCLES_PER_SEC(CPS)) system_watchdog_timer_i (
    .i_core_clk  (clk),
    .i_rstn      (rstn),
    .i_io_addr   (addr),
    .i_io_wr     (wr),
    .i_io_rd     (rd),
    .i_io_wdata  (wdata),
    .o_io_rdata  (rdata),
    .o_cpu_reset (cpu_rst),
    .o_irq       (irq)
  );

  always #25 clk = ~clk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask : io_wr

  // Read data is registered, so it is looked at one edge after the read edge.
  task automatic io_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    @(posedge clk);
    #1;
    check({24'h000000, rdata}, {24'h000000, exp});
  endtask : io_rd

  // Edges until reset or interrupt shows, counted from the load edge; 0 if none.
  task automatic watch(input int lim, input int exp);
    int n;
    n = 0;
    for (int k = 1; k <= lim && n == 0; k++) begin
      @(posedge clk);
      #1;
      if (cpu_rst === 1'b1 || irq === 1'b1) n = k;
    end
    check(n, exp);
  endtask : watch

  initial begin
    repeat (4) @(posedge clk);
    #1;
    check(cpu_rst, 1'b0);
    check(irq, 1'b0);
    rstn = 1'b1;
    io_rd(16'h002F, 8'h00);
    io_wr(16'h002E, 8'h87);
    io_wr(16'h002E, 8'h87);
    foreach (rows[i]) begin
      io_wr(16'h002E, rows[i][0]);
      io_wr(16'h002F, rows[i][1]);
      io_rd(16'h002F, rows[i][2]);
    end
    io_rd(16'h002E, 8'hF6);
    io_wr(16'h0440, 8'h01);
    watch(20, CPS);
    @(posedge clk);
    #1;
    check(cpu_rst, 1'b0);
    io_wr(16'h0440, 8'h3F);
    watch(300, 63 * CPS);
    io_wr(16'h0440, 8'h02);
    repeat (5) @(posedge clk);
    io_wr(16'h0440, 8'h02);
    watch(40, 2 * CPS);
    io_wr(16'h0440, 8'h03);
    io_rd(16'h0440, 8'h03);
    watch(40, 0);
    io_wr(16'h0440, 8'h40);
    watch(20, 0);
    io_rd(16'h0440, 8'h03);
    io_wr(16'h0440, 8'h05);
    io_wr(16'h0440, 8'h00);
    watch(40, 0);
    io_wr(16'h002E, 8'hF6);
    io_wr(16'h002F, 8'h02);
    watch(40, 2 * CPS);
    io_wr(16'h002E, 8'hF5);
    io_wr(16'h002F, 8'h01);
    io_wr(16'h0440, 8'h01);
    watch(300, 60 * CPS);
    io_wr(16'h002F, 8'h02);
    io_wr(16'h0440, 8'h01);
    watch(20, CPS);
    @(posedge clk);
    #1;
    check({cpu_rst, irq}, 2'b01);
    io_rd(16'h0440, 8'h00);
    check(irq, 1'b0);
    // A reset in mid-count must drop the armed state and every register.
    io_wr(16'h002F, 8'h00);
    io_wr(16'h0440, 8'h02);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    #1;
    check({cpu_rst, irq, rdata}, 10'h000);
    @(posedge clk);
    #1;
    rstn = 1'b1;
    watch(20, 0);
    io_wr(16'h0440, 8'h01);
    watch(20, 0);
    io_wr(16'h002E, 8'h87);
    io_wr(16'h002E, 8'h87);
    io_wr(16'h002E, 8'h30);
    io_wr(16'h002F, 8'h01);
    io_rd(16'h002F, 8'h00);
    io_wr(16'h002E, 8'h07);
    io_wr(16'h002F, 8'h08);
    io_wr(16'h002E, 8'hAA);
    io_rd(16'h002F, 8'h00);
    io_rd(16'h0441, 8'h00);
    final_report();
  end

  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
